// ===== test/btm_monitor.sv
// port checker of the bus throughput monitor
`timescale 1ns/1ps
`default_nettype none
module btm_monitor (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] o_readdata,
  input  wire logic        o_waitrequest,
  input  wire logic        o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // ----------------------------------------
  // request steps
  // ----------------------------------------
  sequence s_taken;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence s_ack;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ack_one_cycle: assert property (s_taken |=> s_ack)
    else $error("request not answered in one cycle");
  a_idle_no_ack: assert property (o_waitrequest && !(i_read || i_write)
    |=> o_waitrequest)
    else $error("acknowledge without a request");
  a_unmapped_zero: assert property (i_read && o_waitrequest
    && i_address >= 8'h80 |=> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_restart_reads_zero: assert property (i_read && o_waitrequest
    && i_address == btm_pkg::OFS_CTRL |=> !o_readdata[1])
    else $error("restart bit read back set");
  a_data_held: assert property ($changed(o_readdata)
    |-> $past((i_read || i_write) && o_waitrequest))
    else $error("read data changed with no request");
  a_irq_clear_cause: assert property ($fell(o_irq)
    |-> $past(i_write && o_waitrequest))
    else $error("interrupt fell without a write");
  a_reset_idle: assert property ($rose(i_rstn)
    |-> o_waitrequest && !o_irq)
    else $error("outputs not idle after reset");
endmodule
bind btm_top btm_monitor u_mon (
  .i_clk         (i_clk),
  .i_rstn        (i_rstn),
  .i_address     (i_address),
  .i_read        (i_read),
  .i_write       (i_write),
  .o_readdata    (o_readdata),
  .o_waitrequest (o_waitrequest),
  .o_irq         (o_irq)
);
`default_nettype wire

// ===== test/btm_port_model.sv
// model of eight monitored memory ports making beats
`timescale 1ns/1ps
`default_nettype none
module btm_port_model (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_rd_on,
  input  wire logic [7:0]  i_wr_on,
  input  wire logic        i_slow,
  input  wire logic        i_video,
  output logic [7:0]       o_rvalid,
  output logic [7:0]       o_rready,
  output logic [7:0]       o_wvalid,
  output logic [7:0]       o_wready,
  output logic [63:0]      o_wstrb
);
  logic                    phase;
  // stall every other cycle in slow mode
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      phase <= 1'b0;
    else
      phase <= ~phase;
  // read beats of a 1080p60 rgb stream, 8 bytes each, at 125 MHz
  localparam logic [15:0]  PACE_NUM = 16'h16C8;
  localparam logic [15:0]  PACE_DEN = 16'h3D09;
  logic [15:0]             pace;
  logic                    pace_hit;
  assign pace_hit = (pace >= PACE_DEN - PACE_NUM);
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      pace <= 16'h0;
    else if (pace_hit)
      pace <= pace + PACE_NUM - PACE_DEN;
    else
      pace <= pace + PACE_NUM;
  assign o_rvalid = i_rd_on & {8{~i_video | pace_hit}};
  assign o_wvalid = i_wr_on;
  assign o_rready = i_rd_on & {8{~i_slow | phase}};
  assign o_wready = i_wr_on & {8{~i_slow | phase}};
  // slot g writes 8-g lanes; idle strobes inverted
  for (genvar g = 0; g < 8; g++)
  begin : g_strb
    assign o_wstrb[8*g +: 8] = o_wvalid[g] ? (8'hFF >> g) : ~(8'hFF >> g);
  end
endmodule
`default_nettype wire

// ===== test/btm_top_bench.sv
// self-checking bench of the bus throughput monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    if ((got) !== (exp)) \
      bad_count++; \
  end
module btm_top_bench;
  localparam logic [31:0] IVL = 32'h64;
  // one eight-thousandth of a second, and a full-hd rgb stream in it
  localparam logic [31:0] VID_IVL = btm_pkg::INTERVAL_RST / 32'h1F40;
  localparam logic [31:0] VID_BYTES = 32'h780 * 32'h438 * 32'h3 * 32'h3C
                                      / 32'h1F40;
  typedef struct {logic [7:0] rd; logic [7:0] wr; logic [7:0] en;
                  logic slow; logic [31:0] beats;} btm_row_t;
  logic        i_clk, i_rstn, i_read, i_write, o_waitrequest, o_irq;
  logic        slow, video;
  logic [7:0]  i_address, rd_on, wr_on, rv, rr, wv, wr;
  logic [31:0] i_writedata, o_readdata, rq, ex;
  logic [3:0]  i_byteenable;
  logic [63:0] ws;
  int          bad_count, cmp_count, cyc;
  btm_row_t    rows [3] = '{'{8'hFF, 8'hFF, 8'hFF, 1'b0, 32'h64},
                            '{8'h0F, 8'hF0, 8'hA5, 1'b1, 32'h32},
                            '{8'h5A, 8'h3C, 8'hFF, 1'b1, 32'h32}};

  btm_top #(.P_INTERVAL_RST(IVL)) dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_irq(o_irq), .i_slot_rvalid(rv),
    .i_slot_rready(rr), .i_slot_wvalid(wv), .i_slot_wready(wr),
    .i_slot_wstrb(ws));
  btm_port_model u_ports (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_rd_on(rd_on), .i_wr_on(wr_on),
    .i_slow(slow), .i_video(video), .o_rvalid(rv), .o_rready(rr),
    .o_wvalid(wv),
    .o_wready(wr), .o_wstrb(ws));

  // ----------------------------------------
  // clock, timeout, closing
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // bus and wait tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    i_read <= ~w;
    i_write <= w;
    i_address <= a;
    i_writedata <= d;
    do
    begin
      @(posedge i_clk);
    end
    while (o_waitrequest !== 1'b0);
    rq = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic wait_irq();
    while (o_irq !== 1'b1)
    begin
      @(posedge i_clk);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {i_read, i_write, slow, video, i_address, rd_on, wr_on} = '0;
    i_writedata = 32'h0;
    i_byteenable = 4'hF;
    i_rstn = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    foreach (rows[r])
    begin
      bus(1'b1, btm_pkg::OFS_SLOT_EN, {24'h0, rows[r].en});
      rd_on <= rows[r].rd;
      wr_on <= rows[r].wr;
      slow <= rows[r].slow;
      bus(1'b1, btm_pkg::OFS_MASK, 32'h1);
      bus(1'b1, btm_pkg::OFS_CTRL, 32'h1);
      wait_irq();
      bus(1'b1, btm_pkg::OFS_STATUS, 32'h1);
      wait_irq();
      bus(1'b0, btm_pkg::OFS_STATUS, 32'h0);
      `CHK(rq[0], 1'b1)
      bus(1'b1, btm_pkg::OFS_STATUS, 32'h1);
      bus(1'b1, btm_pkg::OFS_CTRL, 32'h0);
      for (int g = 0; g < 8; g++)
      begin
        ex = (rows[r].en[g] & rows[r].rd[g]) ? rows[r].beats * 8 : 0;
        bus(1'b0, 8'(8'h40 + 8 * g), 32'h0);
        `CHK(rq, ex)
        ex = (rows[r].en[g] & rows[r].wr[g]) ? rows[r].beats * (8 - g) : 0;
        bus(1'b0, 8'(8'h44 + 8 * g), 32'h0);
        `CHK(rq, ex)
      end
    end
    // second reset in mid-run
    bus(1'b1, btm_pkg::OFS_CTRL, 32'h1);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    bus(1'b0, btm_pkg::OFS_INTERVAL, 32'h0);
    `CHK(rq, IVL)
    bus(1'b0, btm_pkg::OFS_SLOT_EN, 32'h0);
    `CHK(rq, 32'h000000FF)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rq, 32'h0)
    // unmapped and restart read-back
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    `CHK(rq, 32'h0)
    bus(1'b0, 8'h80, 32'h0);
    `CHK(rq, 32'h0)
    bus(1'b1, btm_pkg::OFS_CTRL, 32'h3);
    bus(1'b0, btm_pkg::OFS_CTRL, 32'h0);
    `CHK(rq, 32'h1)
    // masked interrupt and overrun, then unmask and clear
    do
    begin
      bus(1'b0, btm_pkg::OFS_STATUS, 32'h0);
    end
    while (rq[0] !== 1'b1);
    `CHK(o_irq, 1'b0)
    repeat (IVL) @(posedge i_clk);
    bus(1'b0, btm_pkg::OFS_STATUS, 32'h0);
    `CHK(rq, 32'h3)
    bus(1'b1, btm_pkg::OFS_CTRL, 32'h0);
    bus(1'b1, btm_pkg::OFS_MASK, 32'h1);
    `CHK(o_irq, 1'b1)
    bus(1'b1, btm_pkg::OFS_STATUS, 32'h3);
    `CHK(o_irq, 1'b0)
    // one scaled interval of a full-hd read stream on every port
    rd_on <= 8'hFF;
    wr_on <= 8'h00;
    slow <= 1'b0;
    video <= 1'b1;
    bus(1'b1, btm_pkg::OFS_INTERVAL, VID_IVL);
    bus(1'b1, btm_pkg::OFS_CTRL, 32'h1);
    wait_irq();
    bus(1'b1, btm_pkg::OFS_CTRL, 32'h0);
    for (int g = 0; g < 8; g++)
    begin
      bus(1'b0, 8'(8'h40 + 8 * g), 32'h0);
      `CHK(rq, VID_BYTES)
    end
    test_done();
  end
endmodule
`default_nettype wire

// ===== verilog/btm_pkg.sv
// constants and register map of the bus throughput monitor
`default_nettype none
package btm_pkg;

  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int unsigned   SLOTS         = 8;
  localparam int unsigned   STRB_W        = 8;
  localparam int unsigned   ADDR_W        = 8;
  localparam logic [3:0]    RD_BEAT_BYTES = 4'h8;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned   CLK_MHZ       = 125;
  localparam int unsigned   INTERVAL_US   = 1000000;
  localparam logic [31:0]   INTERVAL_RST  = 32'(CLK_MHZ * INTERVAL_US);

  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0]    OFS_CTRL      = 8'h00;
  localparam logic [7:0]    OFS_SLOT_EN   = 8'h04;
  localparam logic [7:0]    OFS_INTERVAL  = 8'h08;
  localparam logic [7:0]    OFS_INT_COUNT = 8'h0C;
  localparam logic [7:0]    OFS_STATUS    = 8'h10;
  localparam logic [7:0]    OFS_MASK      = 8'h14;
  localparam logic [1:0]    METRIC_PAGE   = 2'h1;

  // --------------------------------------------------------------
  // fields and reset values
  // --------------------------------------------------------------
  localparam int unsigned   CTRL_RUN      = 0;
  localparam int unsigned   CTRL_RESTART  = 1;
  localparam int unsigned   ST_DONE       = 0;
  localparam int unsigned   ST_OVERRUN    = 1;
  localparam logic [7:0]    SLOT_EN_RST   = 8'hFF;
  localparam logic [1:0]    MASK_RST      = 2'h0;

endpackage
`default_nettype wire

// ===== verilog/btm_slot.sv
// per-slot read and write byte accumulator with metric registers
`timescale 1ns/1ps
`default_nettype none
module btm_slot (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  btm_slot_if.slot          bus
);

  logic [31:0]              acc_rd;
  logic [31:0]              acc_wr;
  logic [3:0]               rd_inc;
  logic [3:0]               wr_inc;
  logic [31:0]              rd_sum;
  logic [31:0]              wr_sum;

  // --------------------------------------------------------------
  // bytes this cycle
  // --------------------------------------------------------------
  always_comb
  begin
    wr_inc = 4'h0;
    for (int b = 0; b < btm_pkg::STRB_W; b++)
    begin
      wr_inc = wr_inc + {3'h0, bus.wr_strb[b]};
    end
    if (!bus.wr_beat || !bus.enable)
    begin
      wr_inc = 4'h0;
    end
  end

  assign rd_inc = (bus.rd_beat && bus.enable) ? btm_pkg::RD_BEAT_BYTES
                                              : 4'h0;
  assign rd_sum = acc_rd + {28'h0, rd_inc};
  assign wr_sum = acc_wr + {28'h0, wr_inc};

  // --------------------------------------------------------------
  // accumulators and metric registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      acc_rd       <= 32'h0;
      acc_wr       <= 32'h0;
      bus.rd_total <= 32'h0;
      bus.wr_total <= 32'h0;
    end
    else if (bus.snap)
    begin
      bus.rd_total <= rd_sum;
      bus.wr_total <= wr_sum;
      acc_rd       <= 32'h0;
      acc_wr       <= 32'h0;
    end
    else if (bus.clear)
    begin
      acc_rd       <= 32'h0;
      acc_wr       <= 32'h0;
    end
    else
    begin
      acc_rd       <= rd_sum;
      acc_wr       <= wr_sum;
    end
  end

endmodule
`default_nettype wire

// ===== verilog/btm_slot_if.sv
// link between the monitor core and one slot accumulator
`timescale 1ns/1ps
`default_nettype none
interface btm_slot_if;
  logic                     rd_beat;
  logic                     wr_beat;
  logic [7:0]               wr_strb;
  logic                     enable;
  logic                     snap;
  logic                     clear;
  logic [31:0]              rd_total;
  logic [31:0]              wr_total;

  modport core (output rd_beat, wr_beat, wr_strb, enable, snap, clear,
                input  rd_total, wr_total);
  modport slot (input  rd_beat, wr_beat, wr_strb, enable, snap, clear,
                output rd_total, wr_total);
endinterface
`default_nettype wire

// ===== verilog/btm_top.sv
// bus throughput monitor: eight slots, interval timer, avalon slave
//
// Contract
// - Up to eight AXI ports are watched, each by its own slot.
// - Every slot counts only its own port; counts never merge.
// - Each port keeps separate read byte and write byte totals.
// - On interval overflow the totals are copied into metric registers.
// - Each completed interval sets a done flag that software polls.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module btm_top #(
  parameter logic [31:0]    P_INTERVAL_RST = btm_pkg::INTERVAL_RST
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [7:0]   i_address,
  input  wire logic         i_read,
  input  wire logic         i_write,
  input  wire logic [31:0]  i_writedata,
  input  wire logic [3:0]   i_byteenable,
  output logic [31:0]       o_readdata,
  output logic              o_waitrequest,
  output logic              o_irq,
  input  wire logic [7:0]   i_slot_rvalid,
  input  wire logic [7:0]   i_slot_rready,
  input  wire logic [7:0]   i_slot_wvalid,
  input  wire logic [7:0]   i_slot_wready,
  input  wire logic [63:0]  i_slot_wstrb
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  logic                     run;
  logic [7:0]               slot_en;
  logic [31:0]              interval;
  logic [31:0]              int_count;
  logic [1:0]               status;
  logic [1:0]               mask;
  logic                     restart;

  logic [31:0]              slot_rd_total [8];
  logic [31:0]              slot_wr_total [8];

  // --------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------
  wire                      bus_go;
  wire                      wr_go;
  wire                      sel_ctrl;
  wire                      sel_slot_en;
  wire                      sel_interval;
  wire                      sel_status;
  wire                      sel_mask;
  wire                      sel_metric;
  wire [2:0]                metric_slot;
  wire                      metric_wr_sel;

  assign bus_go        = (i_read || i_write) && o_waitrequest;
  assign wr_go         = i_write && o_waitrequest;
  assign sel_ctrl      = (i_address == btm_pkg::OFS_CTRL);
  assign sel_slot_en   = (i_address == btm_pkg::OFS_SLOT_EN);
  assign sel_interval  = (i_address == btm_pkg::OFS_INTERVAL);
  assign sel_status    = (i_address == btm_pkg::OFS_STATUS);
  assign sel_mask      = (i_address == btm_pkg::OFS_MASK);
  assign sel_metric    = (i_address[7:6] == btm_pkg::METRIC_PAGE) &&
                         (i_address[1:0] == 2'h0);
  assign metric_slot   = i_address[5:3];
  assign metric_wr_sel = i_address[2];

  // --------------------------------------------------------------
  // byte-lane merge
  // --------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0]               ctrl_word;
  wire [31:0]               ctrl_merged;
  wire [31:0]               slot_en_merged;
  wire [31:0]               interval_merged;
  wire [31:0]               mask_merged;
  wire [1:0]                w1c;

  assign ctrl_word       = {30'h0, 1'b0, run};
  assign ctrl_merged     = merge(ctrl_word, i_writedata, i_byteenable);
  assign slot_en_merged  = merge({24'h0, slot_en}, i_writedata,
                                 i_byteenable);
  assign interval_merged = merge(interval, i_writedata, i_byteenable);
  assign mask_merged     = merge({30'h0, mask}, i_writedata, i_byteenable);
  assign w1c             = (wr_go && sel_status && i_byteenable[0])
                           ? i_writedata[1:0] : 2'h0;

  // --------------------------------------------------------------
  // interval timer
  // --------------------------------------------------------------
  wire [31:0]               interval_m1;
  wire                      overflow;

  assign interval_m1 = (interval == 32'h0) ? 32'h0 : interval - 32'h1;
  assign overflow    = run && !restart &&
                       (int_count >= interval_m1);

  // --------------------------------------------------------------
  // next values
  // --------------------------------------------------------------
  wire                      next_run;
  wire [7:0]                next_slot_en;
  wire [31:0]               next_interval;
  wire [31:0]               next_int_count;
  wire [1:0]                next_status;
  wire [1:0]                next_mask;
  wire                      next_restart;
  wire                      next_irq;

  assign next_run       = (wr_go && sel_ctrl)
                          ? ctrl_merged[btm_pkg::CTRL_RUN] : run;
  assign next_restart   = wr_go && sel_ctrl &&
                          ctrl_merged[btm_pkg::CTRL_RESTART];
  assign next_slot_en   = (wr_go && sel_slot_en)
                          ? slot_en_merged[7:0] : slot_en;
  assign next_interval  = (wr_go && sel_interval)
                          ? interval_merged : interval;
  assign next_mask      = (wr_go && sel_mask) ? mask_merged[1:0] : mask;
  assign next_int_count = (!run || restart || overflow)
                          ? 32'h0 : int_count + 32'h1;
  // hardware set wins over software clear
  assign next_status[btm_pkg::ST_DONE] =
           (status[btm_pkg::ST_DONE] && !w1c[btm_pkg::ST_DONE]) ||
           overflow;
  assign next_status[btm_pkg::ST_OVERRUN] =
           (status[btm_pkg::ST_OVERRUN] && !w1c[btm_pkg::ST_OVERRUN]) ||
           (overflow && status[btm_pkg::ST_DONE] &&
            !w1c[btm_pkg::ST_DONE]);
  assign next_irq       = |(next_status & next_mask);

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  wire [31:0]               metric_word;
  wire [31:0]               rd_mux;

  assign metric_word = metric_wr_sel ? slot_wr_total[metric_slot]
                                     : slot_rd_total[metric_slot];
  assign rd_mux = sel_ctrl     ? {31'h0, run}       :
                  sel_slot_en  ? {24'h0, slot_en}   :
                  sel_interval ? interval           :
                  (i_address == btm_pkg::OFS_INT_COUNT) ? int_count :
                  sel_status   ? {30'h0, status}    :
                  sel_mask     ? {30'h0, mask}      :
                  sel_metric   ? metric_word        : 32'h0;

  // --------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      run <= 1'b0;
    end
    else
    begin
      run <= next_run;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      restart <= 1'b0;
    end
    else
    begin
      restart <= next_restart;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      slot_en <= btm_pkg::SLOT_EN_RST;
    end
    else
    begin
      slot_en <= next_slot_en;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      interval <= P_INTERVAL_RST;
    end
    else
    begin
      interval <= next_interval;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      int_count <= 32'h0;
    end
    else
    begin
      int_count <= next_int_count;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      status <= 2'h0;
    end
    else
    begin
      status <= next_status;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mask <= btm_pkg::MASK_RST;
    end
    else
    begin
      mask <= next_mask;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= next_irq;
    end
  end

  // --------------------------------------------------------------
  // avalon answer: one wait cycle, then waitrequest low one cycle
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_waitrequest <= 1'b1;
      o_readdata    <= 32'h0;
    end
    else if (bus_go)
    begin
      o_waitrequest <= 1'b0;
      o_readdata    <= i_read ? rd_mux : 32'h0;
    end
    else
    begin
      o_waitrequest <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // monitoring slots
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < btm_pkg::SLOTS; g++)
    begin : g_slot
      btm_slot_if slot_bus ();

      assign slot_bus.rd_beat  = i_slot_rvalid[g] &&
                                 i_slot_rready[g];
      assign slot_bus.wr_beat  = i_slot_wvalid[g] &&
                                 i_slot_wready[g];
      assign slot_bus.wr_strb  = i_slot_wstrb[8*g +: 8];
      assign slot_bus.enable   = run && slot_en[g];
      assign slot_bus.snap     = overflow;
      assign slot_bus.clear    = restart || !run;
      assign slot_rd_total[g]  = slot_bus.rd_total;
      assign slot_wr_total[g]  = slot_bus.wr_total;

      btm_slot u_slot (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .bus    (slot_bus.slot)
      );
    end
  endgenerate

endmodule
`default_nettype wire
